// File: hw/result_status_pkg.sv
package result_status_pkg;

    // ------------------------------------------------------------
    // Termination codes
    // ------------------------------------------------------------
    localparam logic [1:0] TERM_NORMAL   = 2'h0;
    localparam logic [1:0] TERM_ABNORMAL = 2'h1;
    localparam logic [1:0] TERM_INVALID  = 2'h2;
    localparam logic [1:0] TERM_POLLING  = 2'h3;

    // ------------------------------------------------------------
    // Field positions and constants
    // ------------------------------------------------------------
    localparam logic [7:0] BAD_TRACK_NUMBER = 8'hFF;
    localparam int         RECAL_STEP_LIMIT = 80;
    localparam int         RESULT_BYTES_MAX = 4;
    localparam logic [2:0] COUNT_ONE        = 3'h1;

    // Packed layouts of the four result bytes.
    typedef struct packed {
        logic [1:0] termination_code;
        logic       positioning_done;
        logic       equipment_fault;
        logic       zero_bit;
        logic       head_address;
        logic [1:0] drive_number;
    } termination_status_type;

    typedef struct packed {
        logic track_end_reached;
        logic zero_bit6;
        logic crc_error_any_field;
        logic service_late_flag;
        logic zero_bit3;
        logic sector_absent;
        logic write_blocked;
        logic id_or_data_mark_absent;
    } transfer_error_type;

    typedef struct packed {
        logic zero_bit7;
        logic unexpected_mark_type;
        logic crc_error_data_field;
        logic track_mismatch;
        logic zero_bit3;
        logic zero_bit2;
        logic bad_track_marker;
        logic data_mark_absent;
    } field_error_type;

    typedef struct packed {
        logic       zero_bit7;
        logic       write_protect_state;
        logic       one_bit5;
        logic       track_zero_state;
        logic       one_bit3;
        logic       head_select_state;
        logic [1:0] drive_select_state;
    } drive_pin_state_type;

    // Error, step, write and seek-done events reported by the command engine, one-cycle pulses.
    typedef struct packed {
        logic track_end;
        logic id_crc_error;
        logic data_crc_error;
        logic service_late;
        logic sector_not_found;
        logic id_mark_missing;
        logic data_mark_missing;
        logic mark_type_wrong;
        logic step_out_past_zero;
        logic recal_step;
        logic write_cmd;
        logic seek_done;
    } event_type;

endpackage

// File: hw/floppy_result_status.sv
`timescale 1ns/1ps
// Behaviour
// R1 - byte 0 bits 7:6 carry termination code 00/01/10/11.
// R2 - byte 0 bit 5 set when seek, relative seek or recalibrate completes.
// R3 - byte 0 bit 4 set after 80 steps without track zero, or overstep.
// R4 - byte 0 shows head in bit 2 and drive number in bits 1:0.
// R5 - unused bits of bytes 0, 1 and 2 always read zero.
// R6 - byte 1 bit 7 set when access passes last sector or no terminal count.
// R7 - byte 1 bit 5 set on CRC error in ID or data field.
// R8 - byte 1 bit 4 set when host service comes too late.
// R9 - byte 1 bit 2 set when the requested sector cannot be found.
// R10 - byte 1 bit 1 set if write protect rises during a write command.
// R11 - byte 1 bit 0 set when ID mark or data mark is missing.
// R12 - byte 2 bit 6 set when the data mark type is unexpected.
// R13 - byte 2 bit 5 set on CRC error in the data field.
// R14 - byte 2 bit 4 set when ID track differs from internal track.
// R15 - byte 2 bit 1 set when the differing ID track equals FF.
// R16 - byte 2 bit 0 set when no data or deleted-data mark is found.
// R17 - byte 3 mirrors write protect, track zero, head and drive selects.
// R18 - byte 3 bit 7 reads 0, bits 5 and 3 read 1.
// R19 - result bytes are presented one after another as data reads.
// R20 - command busy stays high until the last result byte is read.
// R21 - host reads only with transfer allowed and direction set to read.
// R22 - flags are captured at termination and held until read.
// R23 - all flags clear when a new command begins.
module floppy_result_status #(
    parameter int STEP_LIMIT = result_status_pkg::RECAL_STEP_LIMIT
) (
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    input  wire logic                         command_start,
    input  wire logic                         command_end,
    input  wire logic [1:0]                   end_code,
    input  wire logic [2:0]                   result_count,
    input  wire logic                         recalibrate_active,
    input  wire logic                         write_active,
    input  wire logic                         track_check,
    input  wire logic [7:0]                   id_track,
    input  wire logic [7:0]                   internal_track,
    input  wire result_status_pkg::event_type events,
    input  wire logic                         write_protect_input,
    input  wire logic                         track_zero_input,
    input  wire logic                         head_select_output,
    input  wire logic [1:0]                   drive_select_output,
    input  wire logic                         result_read,
    output logic [7:0]                        result_data,
    output logic                              host_transfer_allowed,
    output logic                              transfer_direction,
    output logic                              command_busy
);

    // ------------------------------------------------------------
    // Phase machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        IDLE_STATE    = 3'h1,
        EXECUTE_STATE = 3'h2,
        RESULT_STATE  = 3'h4
    } phase_type;

    phase_type phase;
    phase_type next_phase;

    logic [6:0] step_count;
    logic [2:0] byte_index;
    logic [2:0] byte_total;
    logic       write_protect_prev;

    // Sticky flags gathered during execution.
    logic track_end_flag;
    logic crc_any_flag;
    logic crc_data_flag;
    logic service_late_flag;
    logic sector_absent_flag;
    logic write_blocked_flag;
    logic id_mark_flag;
    logic data_mark_flag;
    logic mark_type_flag;
    logic fault_flag;
    logic positioning_flag;
    logic track_mismatch_flag;
    logic bad_track_flag;

    result_status_pkg::termination_status_type byte0;
    result_status_pkg::transfer_error_type     byte1;
    result_status_pkg::field_error_type        byte2;
    result_status_pkg::drive_pin_state_type    byte3;

    // ------------------------------------------------------------
    // Event decoding
    // ------------------------------------------------------------
    wire executing      = (phase == EXECUTE_STATE);
    wire clear_flags    = command_start & ~executing;
    wire wp_rise        = write_protect_input & ~write_protect_prev;
    wire step_limit_hit = recalibrate_active & events.recal_step
                          & ~track_zero_input
                          & (step_count == 7'(STEP_LIMIT - 1));
    wire track_differs  = track_check & (id_track != internal_track);
    wire last_read      = result_read & (byte_index == byte_total - 3'h1);
    wire enter_result   = executing & command_end
                          & (result_count != 3'h0);

    always_comb begin
        next_phase = phase;
        unique case (phase)
            IDLE_STATE: begin
                if (command_start) begin
                    next_phase = EXECUTE_STATE;
                end
            end
            EXECUTE_STATE: begin
                if (command_end) begin
                    next_phase = (result_count != 3'h0) ? RESULT_STATE
                                                        : IDLE_STATE;
                end
            end
            RESULT_STATE: begin
                if (last_read) begin // R20
                    next_phase = IDLE_STATE;
                end
            end
            default: next_phase = IDLE_STATE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phase <= IDLE_STATE;
        end else begin
            phase <= next_phase;
        end
    end

    // ------------------------------------------------------------
    // Step counter and write-protect edge
    // ------------------------------------------------------------
    // Counting stops at the limit so a stuck drive cannot wrap it.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || clear_flags) begin
            step_count <= 7'h00;
        end else if (recalibrate_active && events.recal_step
                     && step_count != 7'(STEP_LIMIT)) begin
            step_count <= step_count + 7'h01;
        end
    end

    // Tracking the pin through reset keeps a protected disk from looking
    // like a fresh rising edge on the first cycle after release.
    always_ff @(posedge sys_clk) begin
        write_protect_prev <= write_protect_input;
    end

    // ------------------------------------------------------------
    // Sticky flags: set only while executing, cleared at start
    // ------------------------------------------------------------
    // A start that arrives during execution is refused, so it never wipes
    // flags while they are being raised and a set always wins.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || clear_flags) begin // R23
            track_end_flag      <= 1'b0;
            crc_any_flag        <= 1'b0;
            crc_data_flag       <= 1'b0;
            service_late_flag   <= 1'b0;
            sector_absent_flag  <= 1'b0;
            write_blocked_flag  <= 1'b0;
            id_mark_flag        <= 1'b0;
            data_mark_flag      <= 1'b0;
            mark_type_flag      <= 1'b0;
            fault_flag          <= 1'b0;
            positioning_flag    <= 1'b0;
            track_mismatch_flag <= 1'b0;
            bad_track_flag      <= 1'b0;
        end else if (executing) begin
            if (events.track_end) track_end_flag <= 1'b1; // R6
            if (events.id_crc_error || events.data_crc_error)
                crc_any_flag <= 1'b1; // R7
            if (events.data_crc_error) crc_data_flag <= 1'b1; // R13
            if (events.service_late) service_late_flag <= 1'b1; // R8
            if (events.sector_not_found)
                sector_absent_flag <= 1'b1; // R9
            if (write_active && wp_rise)
                write_blocked_flag <= 1'b1; // R10
            if (events.id_mark_missing || events.data_mark_missing)
                id_mark_flag <= 1'b1; // R11
            if (events.data_mark_missing) data_mark_flag <= 1'b1; // R16
            if (events.mark_type_wrong) mark_type_flag <= 1'b1; // R12
            if (step_limit_hit || events.step_out_past_zero)
                fault_flag <= 1'b1; // R3
            if (events.seek_done) positioning_flag <= 1'b1; // R2
            if (track_differs) begin
                track_mismatch_flag <= 1'b1; // R14
                if (id_track == result_status_pkg::BAD_TRACK_NUMBER)
                    bad_track_flag <= 1'b1; // R15
            end
        end
    end

    // ------------------------------------------------------------
    // Snapshot at termination
    // ------------------------------------------------------------
    // The first byte leaves in the cycle it is captured, so the two
    // bytes that can lead a result phase are built here for both uses.
    wire [7:0] fresh_byte0 = {end_code,            // R1
                              positioning_flag,
                              fault_flag,
                              1'h0,                // R5
                              head_select_output,  // R4
                              drive_select_output};
    wire [7:0] fresh_byte3 = {1'h0,                // R18
                              write_protect_input, // R17
                              1'h1,
                              track_zero_input,
                              1'h1,
                              head_select_output,
                              drive_select_output};

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            byte0 <= '0;
            byte1 <= '0;
            byte2 <= '0;
            byte3 <= '0;
        end else if (enter_result) begin // R22
            byte0                        <= fresh_byte0;
            byte1.track_end_reached      <= track_end_flag;
            byte1.zero_bit6              <= 1'b0;
            byte1.crc_error_any_field    <= crc_any_flag;
            byte1.service_late_flag      <= service_late_flag;
            byte1.zero_bit3              <= 1'b0;
            byte1.sector_absent          <= sector_absent_flag;
            byte1.write_blocked          <= write_blocked_flag;
            byte1.id_or_data_mark_absent <= id_mark_flag;
            byte2.zero_bit7              <= 1'b0;
            byte2.unexpected_mark_type   <= mark_type_flag;
            byte2.crc_error_data_field   <= crc_data_flag;
            byte2.track_mismatch         <= track_mismatch_flag;
            byte2.zero_bit3              <= 1'b0;
            byte2.zero_bit2              <= 1'b0;
            byte2.bad_track_marker       <= bad_track_flag;
            byte2.data_mark_absent       <= data_mark_flag;
            byte3                        <= fresh_byte3;
        end
    end

    // ------------------------------------------------------------
    // Result byte sequencing
    // ------------------------------------------------------------
    // A count of 1 serves the drive-state command, whose single byte
    // is the pin mirror rather than the termination byte.
    localparam logic [2:0] RESULT_LIMIT =
        3'(result_status_pkg::RESULT_BYTES_MAX);

    // At termination the index and count still hold the last command's
    // values, so the fresh count and bytes stand in for them then.
    wire [2:0] clamped_count = (result_count > RESULT_LIMIT) ? RESULT_LIMIT
                                                             : result_count;
    wire [2:0] shown_total = enter_result ? clamped_count : byte_total;
    wire       pin_only    = (shown_total == result_status_pkg::COUNT_ONE);
    wire [2:0] next_index  = enter_result ? 3'h0
                           : result_read  ? byte_index + 3'h1 : byte_index;
    wire [7:0] lead_byte   = enter_result ? fresh_byte0 : byte0;
    wire [7:0] pin_byte    = enter_result ? fresh_byte3 : byte3;
    logic [7:0] next_data;

    always_comb begin
        if (pin_only) begin
            next_data = pin_byte;
        end else begin
            unique case (next_index[1:0])
                2'h0:    next_data = lead_byte;
                2'h1:    next_data = byte1;
                2'h2:    next_data = byte2;
                default: next_data = byte3;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            byte_index <= 3'h0;
            byte_total <= 3'h0;
        end else if (enter_result) begin
            byte_index <= 3'h0;
            byte_total <= clamped_count;
        end else if (phase == RESULT_STATE && result_read) begin
            byte_index <= byte_index + 3'h1; // R19
        end
    end

    // Outputs are registered from the next phase and index, so they change in the same cycle as them.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            result_data           <= 8'h00;
            host_transfer_allowed <= 1'b1;
            transfer_direction    <= 1'b0;
            command_busy          <= 1'b0;
        end else begin
            result_data           <= (next_phase == RESULT_STATE)
                                     ? next_data : 8'h00; // R19
            host_transfer_allowed <= (next_phase != EXECUTE_STATE);
            transfer_direction    <= (next_phase == RESULT_STATE); // R21
            command_busy          <= (next_phase != IDLE_STATE); // R20
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_busy_holds_result: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (phase == RESULT_STATE && !last_read) |=> command_busy) // R20
        else $error("busy dropped before last result byte");

    a_result_direction: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        enter_result |=> ##[0:1] (transfer_direction
                                  && host_transfer_allowed)) // R21
        else $error("result phase not flagged for reading");

    a_zero_bits: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        !byte0[3] && !byte1[6] && !byte1[3]
        && !byte2[7] && !byte2[3] && !byte2[2]) // R5
        else $error("unused status bit not zero");

    a_pin_byte_fixed: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        enter_result |=> (byte3[5] && byte3[3] && !byte3[7])) // R18
        else $error("pin byte fixed bits wrong");

    a_code_captured: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        enter_result |=> byte0[7:6] == $past(end_code)) // R1
        else $error("termination code not captured");

    a_snapshot_stable: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (phase == RESULT_STATE && !enter_result) |=> $stable(byte1)) // R22
        else $error("result byte changed during result phase");

    a_flags_cleared: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        clear_flags |=> !crc_any_flag && !fault_flag
                          && !track_mismatch_flag) // R23
        else $error("flags not cleared at command start");

    a_bad_needs_mismatch: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        bad_track_flag |-> track_mismatch_flag) // R15
        else $error("bad track without track mismatch");

    a_crc_data_any: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        crc_data_flag |-> crc_any_flag) // R13
        else $error("data crc flag without any-field flag");

    a_step_fault: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (executing && step_limit_hit && !clear_flags) |=> fault_flag) // R3
        else $error("step limit did not raise fault");

endmodule

// File: tb/drive_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Drive cable model
// ------------------------------------------------------------
// The head walks one track toward zero on each step pulse and stops at
// zero, so the track zero line only rises once the steps have run out.
module drive_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       step,
    input  wire logic       load,
    input  wire logic [7:0] load_track,
    input  wire logic       wp_tab,
    output logic            write_protect_input,
    output logic            track_zero_input
);
    logic [7:0] position;

    assign track_zero_input = (position == 8'h00);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            position            <= 8'h05;
            write_protect_input <= 1'h0;
        end else begin
            write_protect_input <= wp_tab;
            if (load) begin
                position <= load_track;
            end else if (step && position != 8'h00) begin
                position <= position - 8'h01;
            end
        end
    end
endmodule

// File: tb/floppy_result_status_tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Result byte testbench
// ------------------------------------------------------------
module floppy_result_status_tb;
    typedef struct packed {
        logic [1:0]                   code;
        result_status_pkg::event_type ev;
        logic                         chk;
        logic [7:0]                   idt;
        logic                         head;
        logic [1:0]                   ds;
        logic [31:0]                  exp;
    } row_type;

    logic       sys_clk = 1'h0, rst_n = 1'h0, command_start = 1'h0;
    logic       command_end = 1'h0, recalibrate_active = 1'h0;
    logic       write_active = 1'h0, track_check = 1'h0;
    logic       head_select_output = 1'h0, result_read = 1'h0;
    logic       load = 1'h0, wp_tab = 1'h0;
    logic [1:0] end_code = 2'h0, drive_select_output = 2'h0;
    logic [2:0] result_count = 3'h0;
    logic [7:0] id_track = 8'h00, internal_track = 8'h05;
    logic [7:0] load_track = 8'h00, result_data;
    logic       write_protect_input, track_zero_input;
    logic       host_transfer_allowed, transfer_direction, command_busy;
    int         fails = 0, samples_checked = 0;
    result_status_pkg::event_type events = '0;

    // Expected bytes are packed first byte highest.
    row_type rows [13] = '{
        '{2'h0, 12'h000, 1'h0, 8'h00, 1'h0, 2'h0, 32'h00000028},
        '{2'h1, 12'h800, 1'h0, 8'h00, 1'h1, 2'h1, 32'h4580002D},
        '{2'h2, 12'h400, 1'h0, 8'h00, 1'h0, 2'h2, 32'h8220002A},
        '{2'h3, 12'h200, 1'h0, 8'h00, 1'h1, 2'h3, 32'hC720202F},
        '{2'h1, 12'h180, 1'h0, 8'h00, 1'h0, 2'h0, 32'h40140028},
        '{2'h1, 12'h040, 1'h0, 8'h00, 1'h0, 2'h0, 32'h40010028},
        '{2'h1, 12'h020, 1'h0, 8'h00, 1'h0, 2'h0, 32'h40010128},
        '{2'h1, 12'h010, 1'h0, 8'h00, 1'h0, 2'h0, 32'h40004028},
        '{2'h1, 12'h008, 1'h0, 8'h00, 1'h0, 2'h0, 32'h50000028},
        '{2'h0, 12'h001, 1'h0, 8'h00, 1'h0, 2'h0, 32'h20000028},
        '{2'h1, 12'h000, 1'h1, 8'h03, 1'h0, 2'h0, 32'h40001028},
        '{2'h1, 12'h000, 1'h1, 8'hFF, 1'h0, 2'h0, 32'h40001228},
        '{2'h0, 12'h000, 1'h1, 8'h05, 1'h0, 2'h0, 32'h00000028}
    };

    always #12.5 sys_clk = ~sys_clk;

    floppy_result_status #(.STEP_LIMIT(4)) floppy_result_status_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .command_start(command_start),
        .command_end(command_end), .end_code(end_code),
        .result_count(result_count),
        .recalibrate_active(recalibrate_active),
        .write_active(write_active), .track_check(track_check),
        .id_track(id_track), .internal_track(internal_track),
        .events(events), .write_protect_input(write_protect_input),
        .track_zero_input(track_zero_input),
        .head_select_output(head_select_output),
        .drive_select_output(drive_select_output),
        .result_read(result_read), .result_data(result_data),
        .host_transfer_allowed(host_transfer_allowed),
        .transfer_direction(transfer_direction),
        .command_busy(command_busy)
    );

    drive_model drive_model_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .step(events.recal_step),
        .load(load), .load_track(load_track), .wp_tab(wp_tab),
        .write_protect_input(write_protect_input),
        .track_zero_input(track_zero_input)
    );

    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task check(input string name, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", name, e, g);
            fails++;
        end
    endtask

    task begin_cmd;
        @(posedge sys_clk);
        command_start <= 1'h1;
        @(posedge sys_clk);
        command_start <= 1'h0;
    endtask

    task end_cmd(input logic [1:0] code, input logic [2:0] cnt);
        #1;
        check("execute flags", 8'h01, {5'h00, host_transfer_allowed,
              transfer_direction, command_busy});
        @(posedge sys_clk);
        command_end  <= 1'h1;
        end_code     <= code;
        result_count <= cnt;
        events       <= '0;
        track_check  <= 1'h0;
        @(posedge sys_clk);
        command_end <= 1'h0;
    endtask

    task read_all(input logic [31:0] e, input int n);
        int i;
        int k;
        k = 0;
        #1;
        while (transfer_direction !== 1'h1 && k < 20) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        if (k == 20) begin
            fails++;
            finish_test;
        end
        for (i = 0; i < n; i++) begin
            check("transfer flags", 8'h07, {5'h00, host_transfer_allowed,
                  transfer_direction, command_busy});
            check("result byte", e[8*(n-1-i)+:8], result_data);
            @(posedge sys_clk);
            result_read <= 1'h1;
            @(posedge sys_clk);
            result_read <= 1'h0;
            #1;
        end
        check("idle data", 8'h00, result_data);
        check("idle flags", 8'h04, {5'h00, host_transfer_allowed,
              transfer_direction, command_busy});
    endtask

    task recal(input logic [7:0] pos, input int n, input logic [31:0] e);
        @(posedge sys_clk);
        load       <= 1'h1;
        load_track <= pos;
        @(posedge sys_clk);
        load <= 1'h0;
        begin_cmd;
        recalibrate_active <= 1'h1;
        repeat (n) begin
            @(posedge sys_clk);
            events <= 12'h004;
            @(posedge sys_clk);
            events <= 12'h000;
        end
        end_cmd(e[31:30], 3'h4);
        recalibrate_active <= 1'h0;
        read_all(e, 4);
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        check("reset data", 8'h00, result_data);
        check("reset flags", 8'h04, {5'h00, host_transfer_allowed,
              transfer_direction, command_busy});
        @(posedge sys_clk);
        rst_n <= 1'h1;
        foreach (rows[r]) begin
            begin_cmd;
            head_select_output  <= rows[r].head;
            drive_select_output <= rows[r].ds;
            events              <= rows[r].ev;
            track_check         <= rows[r].chk;
            id_track            <= rows[r].idt;
            end_cmd(rows[r].code, 3'h4);
            read_all(rows[r].exp, 4);
        end
        // One step short of the limit reaches track zero without a fault.
        recal(8'h03, 3, 32'h00000038);
        recal(8'h0A, 4, 32'h50000028);
        begin_cmd;
        write_active <= 1'h1;
        @(posedge sys_clk);
        wp_tab <= 1'h1;
        repeat (3) @(posedge sys_clk);
        end_cmd(2'h1, 3'h4);
        write_active <= 1'h0;
        read_all(32'h40020068, 4);
        // Protection already on before the write is no rising edge.
        begin_cmd;
        write_active <= 1'h1;
        repeat (3) @(posedge sys_clk);
        end_cmd(2'h1, 3'h4);
        write_active <= 1'h0;
        read_all(32'h40000068, 4);
        @(posedge sys_clk);
        wp_tab <= 1'h0;
        begin_cmd;
        end_cmd(2'h0, 3'h4);
        events <= 12'hFF9;
        @(posedge sys_clk);
        events <= 12'h000;
        read_all(32'h00000028, 4);
        begin_cmd;
        end_cmd(2'h2, 3'h1);
        read_all(32'h00000028, 1);
        begin_cmd;
        end_cmd(2'h0, 3'h0);
        repeat (2) @(posedge sys_clk);
        #1;
        check("no result flags", 8'h04, {5'h00, host_transfer_allowed,
              transfer_direction, command_busy});
        finish_test;
    end
endmodule
